// [inc/smbus_iw_pkg.sv]
// Purpose: shared constants for the index block write link
// Assumes: 20 MHz system clock on both ends
// Notes:   addresses are 7-bit, the direction bit is appended on the wire
package smbus_iw_pkg;

    // clock and link timing
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned SMBUS_MAX_HZ     = 500000;
    localparam int unsigned SMBUS_MIN_PER_NS = 1000000000 / SMBUS_MAX_HZ;
    localparam int unsigned SCL_PERIOD_NS    = 10000;

    // target addresses chosen by the strap level
    localparam logic [6:0] ADDR_STRAP_LOW  = 7'h68;
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h6A;
    localparam logic       DIR_WRITE       = 1'b0;

    // bit positions inside one byte frame
    localparam logic [3:0] BIT_LAST_DATA = 4'h8;
    localparam logic [3:0] BIT_ACK_DONE  = 4'h9;

    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage

// [inc/smbus_link_if.sv]
// Purpose: two-wire link between host and device ends
// Assumes: open-drain wires with pull-ups, modelled here
// Notes:   an enable low means the end pulls the wire
`timescale 1ns/100ps
`default_nettype none
interface smbus_link_if;
    // host drivers
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    // device drivers
    logic dev_sda_o;
    logic dev_sda_oe_n;
    // resolved wire levels
    logic scl;
    logic sda;

    // wired-and with pull-ups
    assign scl = host_scl_oe_n ? 1'b1 : host_scl_o;
    assign sda = (!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o) ? 1'b0 : 1'b1;

    modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
                  output host_sda_o, output host_sda_oe_n);
endinterface
`default_nettype wire

// [logic/smbus_iw_device.sv]
// Purpose: target end of the index block write transaction
// Assumes: scl and sda are synchronous to clk, host clock far slower than clk
// Notes:   no clock stretching, bytes beyond the count are refused
//
// Operation
// [RULE_01] host opens with a start condition
// [RULE_02] address with write bit, acked on match
// [RULE_03] index byte follows and is acked
// [RULE_04] byte count follows and is acked
// [RULE_05] data bytes stored at consecutive indexes
// [RULE_06] every data byte acked on its own
// [RULE_07] host ends with a stop condition
// [RULE_08] target address taken from latched strap
// [RULE_09] msb first, ack low on ninth clock
`timescale 1ns/100ps
`default_nettype none
module smbus_iw_device (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // strap
    input  wire logic        address_select_strap,
    // link
    smbus_link_if.device     bus,
    // register write port
    output logic             wr_strobe,
    output logic [7:0]       wr_index,
    output logic [7:0]       wr_data,
    // status
    output logic             busy,
    output logic             xfer_done,
    output logic             xfer_abort,
    output logic [6:0]       target_addr
);

    ////////////////////////////////////////////////////////////////////////////
    // types and state

    typedef enum logic [5:0] {
        PH_IDLE  = 6'b00_0001,
        PH_ADDR  = 6'b00_0010,
        PH_INDEX = 6'b00_0100,
        PH_COUNT = 6'b00_1000,
        PH_DATA  = 6'b01_0000,
        PH_SKIP  = 6'b10_0000
    } phase_t;

    phase_t     phase_reg,     phase_next;
    logic [3:0] bit_cnt_reg,   bit_cnt_next;
    logic [7:0] shift_reg,     shift_next;
    logic [7:0] index_reg,     index_next;
    logic [7:0] remain_reg,    remain_next;
    logic       scl_prev_reg,  scl_prev_next;
    logic       sda_prev_reg,  sda_prev_next;
    logic       sda_oe_n_reg,  sda_oe_n_next;
    logic       strap_taken_reg, strap_taken_next;
    logic       strap_sel_reg, strap_sel_next;
    logic       wr_strobe_reg, wr_strobe_next;
    logic [7:0] wr_index_reg,  wr_index_next;
    logic [7:0] wr_data_reg,   wr_data_next;
    logic       busy_reg,      busy_next;
    logic       done_reg,      done_next;
    logic       abort_reg,     abort_next;
    logic [6:0] addr_reg,      addr_next;

    logic       start_seen;
    logic       stop_seen;
    logic       scl_rise;
    logic       scl_fall;
    logic       in_frame;

    ////////////////////////////////////////////////////////////////////////////
    // address chosen by strap level

    function automatic logic [6:0] strap_addr(input logic sel);
        strap_addr = sel ? smbus_iw_pkg::ADDR_STRAP_HIGH : smbus_iw_pkg::ADDR_STRAP_LOW;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // line events

    // start and stop are sda edges while scl stays high
    assign start_seen = bus.scl && scl_prev_reg && sda_prev_reg && !bus.sda; // [RULE_01]
    assign stop_seen  = bus.scl && scl_prev_reg && !sda_prev_reg && bus.sda; // [RULE_07]
    assign scl_rise   = bus.scl && !scl_prev_reg;
    assign scl_fall   = !bus.scl && scl_prev_reg;
    assign in_frame   = (phase_reg != PH_IDLE) && (phase_reg != PH_SKIP);

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        phase_next       = phase_reg;
        bit_cnt_next     = bit_cnt_reg;
        shift_next       = shift_reg;
        index_next       = index_reg;
        remain_next      = remain_reg;
        scl_prev_next    = bus.scl;
        sda_prev_next    = bus.sda;
        sda_oe_n_next    = sda_oe_n_reg;
        strap_taken_next = strap_taken_reg;
        strap_sel_next   = strap_sel_reg;
        wr_strobe_next   = 1'b0;
        wr_index_next    = wr_index_reg;
        wr_data_next     = wr_data_reg;
        busy_next        = busy_reg;
        done_next        = 1'b0;
        abort_next       = 1'b0;
        addr_next        = strap_addr(strap_sel_reg);

        // strap caught once, on the first clock after reset
        if (!strap_taken_reg) begin
            strap_sel_next   = address_select_strap; // [RULE_08]
            strap_taken_next = 1'b1;
        end

        if (start_seen) begin
            // a start, repeated or not, always restarts the frame
            phase_next    = PH_ADDR; // [RULE_01]
            bit_cnt_next  = 4'h0;
            sda_oe_n_next = 1'b1;
            busy_next     = 1'b1;
        end else if (stop_seen) begin
            // complete only when every counted byte arrived
            if (phase_reg == PH_DATA && remain_reg == smbus_iw_pkg::BYTE_RESET) begin
                done_next = 1'b1; // [RULE_07]
            end else if (phase_reg == PH_INDEX || phase_reg == PH_COUNT ||
                         phase_reg == PH_DATA) begin
                abort_next = 1'b1;
            end
            phase_next    = PH_IDLE;
            sda_oe_n_next = 1'b1;
            busy_next     = 1'b0;
        end else if (scl_rise && in_frame) begin
            // sample on rising scl, msb first
            if (bit_cnt_reg < smbus_iw_pkg::BIT_LAST_DATA) begin
                shift_next = {shift_reg[6:0], bus.sda}; // [RULE_09]
            end
            bit_cnt_next = bit_cnt_reg + 4'h1;
        end else if (scl_fall && in_frame) begin
            if (bit_cnt_reg == smbus_iw_pkg::BIT_LAST_DATA) begin
                // whole byte in: decide on the ack for the ninth clock
                unique case (phase_reg)
                    PH_ADDR: begin
                        if (shift_reg[7:1] == addr_reg &&
                            shift_reg[0] == smbus_iw_pkg::DIR_WRITE) begin
                            sda_oe_n_next = 1'b0; // [RULE_02]
                            phase_next    = PH_INDEX;
                        end else begin
                            phase_next = PH_SKIP;
                            busy_next  = 1'b0;
                        end
                    end
                    PH_INDEX: begin
                        index_next    = shift_reg;
                        sda_oe_n_next = 1'b0; // [RULE_03]
                        phase_next    = PH_COUNT;
                    end
                    PH_COUNT: begin
                        remain_next   = shift_reg;
                        sda_oe_n_next = 1'b0; // [RULE_04]
                        phase_next    = PH_DATA;
                    end
                    PH_DATA: begin
                        if (remain_reg != smbus_iw_pkg::BYTE_RESET) begin
                            wr_strobe_next = 1'b1; // [RULE_05]
                            wr_index_next  = index_reg;
                            wr_data_next   = shift_reg;
                            index_next     = index_reg + 8'h01;
                            remain_next    = remain_reg - 8'h01;
                            sda_oe_n_next  = 1'b0; // [RULE_06]
                        end else begin
                            // surplus byte: left unacknowledged
                            phase_next = PH_SKIP;
                        end
                    end
                    default: begin
                        phase_next = PH_SKIP;
                    end
                endcase
            end else if (bit_cnt_reg == smbus_iw_pkg::BIT_ACK_DONE) begin
                // ninth clock over: let go of sda
                sda_oe_n_next = 1'b1; // [RULE_09]
                bit_cnt_next  = 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_reg       <= PH_IDLE;
            bit_cnt_reg     <= 4'h0;
            shift_reg       <= smbus_iw_pkg::BYTE_RESET;
            index_reg       <= smbus_iw_pkg::BYTE_RESET;
            remain_reg      <= smbus_iw_pkg::BYTE_RESET;
            scl_prev_reg    <= 1'b1;
            sda_prev_reg    <= 1'b1;
            sda_oe_n_reg    <= 1'b1;
            strap_taken_reg <= 1'b0;
            strap_sel_reg   <= 1'b0;
            wr_strobe_reg   <= 1'b0;
            wr_index_reg    <= smbus_iw_pkg::BYTE_RESET;
            wr_data_reg     <= smbus_iw_pkg::BYTE_RESET;
            busy_reg        <= 1'b0;
            done_reg        <= 1'b0;
            abort_reg       <= 1'b0;
            addr_reg        <= smbus_iw_pkg::ADDR_STRAP_LOW;
        end else begin
            phase_reg       <= phase_next;
            bit_cnt_reg     <= bit_cnt_next;
            shift_reg       <= shift_next;
            index_reg       <= index_next;
            remain_reg      <= remain_next;
            scl_prev_reg    <= scl_prev_next;
            sda_prev_reg    <= sda_prev_next;
            sda_oe_n_reg    <= sda_oe_n_next;
            strap_taken_reg <= strap_taken_next;
            strap_sel_reg   <= strap_sel_next;
            wr_strobe_reg   <= wr_strobe_next;
            wr_index_reg    <= wr_index_next;
            wr_data_reg     <= wr_data_next;
            busy_reg        <= busy_next;
            done_reg        <= done_next;
            abort_reg       <= abort_next;
            addr_reg        <= addr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // open drain: only ever pulls low
    assign bus.dev_sda_o    = 1'b0;
    assign bus.dev_sda_oe_n = sda_oe_n_reg;
    assign wr_strobe        = wr_strobe_reg;
    assign wr_index         = wr_index_reg;
    assign wr_data          = wr_data_reg;
    assign busy             = busy_reg;
    assign xfer_done        = done_reg;
    assign xfer_abort       = abort_reg;
    assign target_addr      = addr_reg;

endmodule // smbus_iw_device
`default_nettype wire

// [logic/smbus_iw_host.sv]
// Purpose: controller end issuing one index block write
// Assumes: no other controller on the wires, target never stretches scl
// Notes:   scl made by dividing clk into quarter-bit ticks
`timescale 1ns/100ps
`default_nettype none
module smbus_iw_host #(
    parameter int unsigned SCL_PERIOD_NS = smbus_iw_pkg::SCL_PERIOD_NS
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // request
    input  wire logic        xfer_start,
    input  wire logic [6:0]  target_addr,
    input  wire logic [7:0]  start_index,
    input  wire logic [7:0]  byte_count,
    // data feed
    input  wire logic [7:0]  byte_in,
    output logic             byte_req,
    // status
    output logic             busy,
    output logic             xfer_done,
    output logic             xfer_nack,
    // link
    smbus_link_if.host       bus
);

    ////////////////////////////////////////////////////////////////////////////
    // timing

    localparam int unsigned PERIOD_NS = (SCL_PERIOD_NS < smbus_iw_pkg::SMBUS_MIN_PER_NS) ?
                                        smbus_iw_pkg::SMBUS_MIN_PER_NS : SCL_PERIOD_NS;
    localparam int unsigned QUARTER   = (PERIOD_NS + 4 * smbus_iw_pkg::CLK_PERIOD_NS - 1) /
                                        (4 * smbus_iw_pkg::CLK_PERIOD_NS);
    localparam logic [15:0] QUARTER_LAST = 16'(QUARTER - 1);

    typedef enum logic [3:0] {
        H_IDLE  = 4'b0001,
        H_START = 4'b0010,
        H_BITS  = 4'b0100,
        H_STOP  = 4'b1000
    } hstate_t;

    typedef enum logic [1:0] {
        F_ADDR  = 2'h0,
        F_INDEX = 2'h1,
        F_COUNT = 2'h2,
        F_DATA  = 2'h3
    } field_t;

    hstate_t    state_reg,  state_next;
    field_t     field_reg,  field_next;
    logic [15:0] div_reg,   div_next;
    logic [1:0] q_reg,      q_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg,  shift_next;
    logic [7:0] index_reg,  index_next;
    logic [7:0] count_reg,  count_next;
    logic [7:0] remain_reg, remain_next;
    logic       acked_reg,  acked_next;
    logic       failed_reg, failed_next;
    logic       scl_oe_n_reg, scl_oe_n_next;
    logic       sda_oe_n_reg, sda_oe_n_next;
    logic       req_reg,    req_next;
    logic       done_reg,   done_next;
    logic       nack_reg,   nack_next;
    logic       tick;

    assign tick = (div_reg == QUARTER_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        state_next    = state_reg;
        field_next    = field_reg;
        div_next      = tick ? 16'h0000 : div_reg + 16'h0001;
        q_next        = q_reg;
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        index_next    = index_reg;
        count_next    = count_reg;
        remain_next   = remain_reg;
        acked_next    = acked_reg;
        failed_next   = failed_reg;
        scl_oe_n_next = scl_oe_n_reg;
        sda_oe_n_next = sda_oe_n_reg;
        req_next      = 1'b0;
        done_next     = 1'b0;
        nack_next     = 1'b0;

        unique case (state_reg)
            H_IDLE: begin
                if (xfer_start) begin
                    state_next  = H_START;
                    q_next      = 2'h0;
                    div_next    = 16'h0000;
                    field_next  = F_ADDR;
                    shift_next  = {target_addr, smbus_iw_pkg::DIR_WRITE}; // [RULE_02]
                    index_next  = start_index;
                    count_next  = byte_count;
                    remain_next = byte_count;
                    failed_next = 1'b0;
                end
            end
            H_START: begin
                if (tick) begin
                    q_next = q_reg + 2'h1;
                    // sda falls while scl high, then scl drops
                    if (q_reg == 2'h1) begin
                        sda_oe_n_next = 1'b0; // [RULE_01]
                    end else if (q_reg == 2'h3) begin
                        scl_oe_n_next = 1'b0;
                        state_next    = H_BITS;
                        bit_cnt_next  = 4'h0;
                    end
                end
            end
            H_BITS: begin
                if (tick) begin
                    q_next = q_reg + 2'h1;
                    unique case (q_reg)
                        2'h0: begin
                            // set data while scl low, msb first; release on ack bit
                            if (bit_cnt_reg < smbus_iw_pkg::BIT_LAST_DATA) begin
                                sda_oe_n_next = shift_reg[7]; // [RULE_09]
                            end else begin
                                sda_oe_n_next = 1'b1;
                            end
                        end
                        2'h1: scl_oe_n_next = 1'b1;
                        2'h2: begin
                            if (bit_cnt_reg == smbus_iw_pkg::BIT_LAST_DATA) begin
                                acked_next = !bus.sda; // [RULE_09]
                            end
                        end
                        2'h3: begin
                            scl_oe_n_next = 1'b0;
                            if (bit_cnt_reg < smbus_iw_pkg::BIT_LAST_DATA) begin
                                shift_next   = {shift_reg[6:0], 1'b0};
                                bit_cnt_next = bit_cnt_reg + 4'h1;
                            end else begin
                                bit_cnt_next = 4'h0;
                                if (!acked_reg) begin
                                    failed_next = 1'b1;
                                    nack_next   = 1'b1;
                                    state_next  = H_STOP;
                                end else begin
                                    // pick the next byte of the sequence
                                    unique case (field_reg)
                                        F_ADDR: begin
                                            field_next = F_INDEX;
                                            shift_next = index_reg; // [RULE_03]
                                        end
                                        F_INDEX: begin
                                            field_next = F_COUNT;
                                            shift_next = count_reg; // [RULE_04]
                                        end
                                        default: begin
                                            field_next = F_DATA;
                                            if (remain_reg == smbus_iw_pkg::BYTE_RESET) begin
                                                state_next = H_STOP; // [RULE_07]
                                            end else begin
                                                shift_next  = byte_in; // [RULE_05]
                                                req_next    = 1'b1;
                                                remain_next = remain_reg - 8'h01;
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
            end
            H_STOP: begin
                if (tick) begin
                    q_next = q_reg + 2'h1;
                    // sda low under low scl, raise scl, then raise sda
                    if (q_reg == 2'h0) begin
                        sda_oe_n_next = 1'b0;
                    end else if (q_reg == 2'h1) begin
                        scl_oe_n_next = 1'b1;
                    end else if (q_reg == 2'h3) begin
                        sda_oe_n_next = 1'b1; // [RULE_07]
                        state_next    = H_IDLE;
                        done_next     = !failed_reg;
                    end
                end
            end
            default: state_next = H_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg    <= H_IDLE;
            field_reg    <= F_ADDR;
            div_reg      <= 16'h0000;
            q_reg        <= 2'h0;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= smbus_iw_pkg::BYTE_RESET;
            index_reg    <= smbus_iw_pkg::BYTE_RESET;
            count_reg    <= smbus_iw_pkg::BYTE_RESET;
            remain_reg   <= smbus_iw_pkg::BYTE_RESET;
            acked_reg    <= 1'b0;
            failed_reg   <= 1'b0;
            scl_oe_n_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
            req_reg      <= 1'b0;
            done_reg     <= 1'b0;
            nack_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            field_reg    <= field_next;
            div_reg      <= div_next;
            q_reg        <= q_next;
            bit_cnt_reg  <= bit_cnt_next;
            shift_reg    <= shift_next;
            index_reg    <= index_next;
            count_reg    <= count_next;
            remain_reg   <= remain_next;
            acked_reg    <= acked_next;
            failed_reg   <= failed_next;
            scl_oe_n_reg <= scl_oe_n_next;
            sda_oe_n_reg <= sda_oe_n_next;
            req_reg      <= req_next;
            done_reg     <= done_next;
            nack_reg     <= nack_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign bus.host_scl_o    = 1'b0;
    assign bus.host_sda_o    = 1'b0;
    assign bus.host_scl_oe_n = scl_oe_n_reg;
    assign bus.host_sda_oe_n = sda_oe_n_reg;
    assign byte_req          = req_reg;
    assign busy              = (state_reg != H_IDLE);
    assign xfer_done         = done_reg;
    assign xfer_nack         = nack_reg;

endmodule // smbus_iw_host
`default_nettype wire

// [dv/smbus_index_block_write_chk.sv]
// Purpose: watches the two-wire link between host and device ends
// Assumes: host quarter tick of 10 clocks
// Notes:   sees the interface wires only
`timescale 1ns/100ps
`default_nettype none
module smbus_index_block_write_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link wires
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0] bit_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // scl rises since the last start, wrapping after nine
    always_ff @(posedge clk) begin
        if (rst || ($fell(sda) && scl)) bit_reg <= 4'h0;
        else if ($rose(scl)) bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // link properties
    a_start_clocks: assert property ($fell(sda) && scl |-> ##[1:40] !scl)
        else $error("no clock after start");
    a_ack_slot: assert property ($fell(dev_sda_oe_n) |-> bit_reg == 4'h8)
        else $error("ack outside ninth slot");
    a_ack_scl_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("ack moved while scl high");
    a_ack_holds: assert property ($rose(scl) && !dev_sda_oe_n |-> !dev_sda_oe_n [*8])
        else $error("ack dropped early");
    a_ack_release: assert property ($fell(dev_sda_oe_n) |-> ##[30:80] dev_sda_oe_n)
        else $error("ack not released");
    a_host_frees: assert property ($rose(scl) && bit_reg == 4'h8 |-> host_sda_oe_n)
        else $error("host holds sda in ack slot");
    a_scl_high: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high too short");
    a_stop_idle: assert property ($rose(sda) && scl && $past(scl)
        |-> (sda && scl && dev_sda_oe_n) [*8])
        else $error("bus busy after stop");
endmodule // smbus_index_block_write_chk
`default_nettype wire

// [dv/smbus_index_block_write_test.sv]
// Purpose: host end writes blocks into device end
// Assumes: quarter tick of 10 clocks
// Notes:   strap changed only across reset
`timescale 1ns/100ps
`default_nettype none
module smbus_index_block_write_test;
    logic       clk = 1'b0, rst = 1'b1, strap = 1'b0, go = 1'b0;
    logic [6:0] addr = 7'h00, tgt;
    logic [6:0] lo = smbus_iw_pkg::ADDR_STRAP_LOW, hi = smbus_iw_pkg::ADDR_STRAP_HIGH;
    logic [7:0] idx = 8'h00, cnt = 8'h00, byte_in, wr_index, wr_data;
    logic       byte_req, h_busy, h_done, h_nack, wr_strobe, d_busy, d_done, d_abort;
    logic [7:0] dat [4] = '{8'hA5, 8'h3C, 8'h96, 8'h0F};
    logic [7:0] wi [$], wd [$];
    int         bi = 0, dn = 0, ab = 0, num_errors = 0, checked = 0;
    always #25 clk = ~clk;
    assign byte_in = dat[bi[1:0]];
    smbus_link_if link ();
    smbus_iw_host #(.SCL_PERIOD_NS(2000)) u_smbus_iw_host (.clk(clk), .rst(rst), .xfer_start(go),
        .target_addr(addr), .start_index(idx), .byte_count(cnt), .byte_in(byte_in),
        .byte_req(byte_req), .busy(h_busy), .xfer_done(h_done), .xfer_nack(h_nack), .bus(link));
    smbus_iw_device u_smbus_iw_device (.clk(clk), .rst(rst), .address_select_strap(strap),
        .bus(link), .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data),
        .busy(d_busy), .xfer_done(d_done), .xfer_abort(d_abort), .target_addr(tgt));
    smbus_index_block_write_chk u_smbus_index_block_write_chk (.clk(clk), .rst(rst),
        .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n),
        .scl(link.scl), .sda(link.sda));
    ////////////////////////////////////////////////////////////////////////////////
    // capture device writes and completions, feed next data byte
    always @(posedge clk) begin
        if (wr_strobe === 1'b1) begin
            wi.push_back(wr_index);
            wd.push_back(wr_data);
        end
        if (d_done === 1'b1) dn++;
        if (d_abort === 1'b1) ab++;
    end
    always @(negedge clk) if (byte_req === 1'b1) bi++;
    ////////////////////////////////////////////////////////////////////////////////
    // compare, reset and transfer tasks
    task automatic cmp(input string nm, input logic [7:0] s, e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask
    task automatic reset_dut(input logic s);
        @(negedge clk);
        rst = 1'b1;
        strap = s;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        cmp("target_addr", {1'b0, tgt}, {1'b0, s ? hi : lo});
    endtask
    task automatic run(input string nm, input logic [6:0] a, input logic [7:0] n, x,
                       input logic nack);
        int t;
        wi.delete();
        wd.delete();
        dn = 0;
        ab = 0;
        @(negedge clk);
        addr = a;
        idx = n;
        cnt = x;
        bi = 0;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        for (t = 0; t < 5000 && h_done !== 1'b1 && h_nack !== 1'b1; t++) @(negedge clk);
        cmp("finish", 8'(t == 5000), 8'h00);
        cmp("nack", {7'h00, h_nack}, {7'h00, nack});
        // the host still sends its stop after a refused byte
        for (t = 0; t < 100 && h_busy !== 1'b0; t++) @(negedge clk);
        repeat (20) @(negedge clk);
        cmp("done", 8'(dn), {7'h00, !nack});
        cmp("abort", 8'(ab), 8'h00);
        cmp("busy", {6'h00, h_busy, d_busy}, 8'h00);
        cmp("writes", 8'(wi.size()), nack ? 8'h00 : x);
        for (t = 0; t < wi.size(); t++) begin
            cmp("wr_index", wi[t], n + 8'(t));
            cmp("wr_data", wd[t], dat[t]);
        end
        $display("test %s ends", nm);
    endtask
    task automatic results();
        $display("checks %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // test sequence and watchdog
    initial begin
        reset_dut(1'b0);
        run("wrap", lo, 8'hFE, 8'h03, 1'b0);
        run("miss", hi, 8'h10, 8'h01, 1'b1);
        run("four", lo, 8'h05, 8'h04, 1'b0);
        run("zero", lo, 8'h20, 8'h00, 1'b0);
        reset_dut(1'b1);
        run("strap", hi, 8'h10, 8'h01, 1'b0);
        run("low", lo, 8'h10, 8'h01, 1'b1);
        results();
    end
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        results();
    end
endmodule // smbus_index_block_write_test
`default_nettype wire
